// ### design/smr_pkg.sv
// Purpose: Shared constants for the sector map table slice
// Assumes: Byte-wide table reads and a 32-bit register port
// Notes: Table dwords are built from these fields in smr_rom
package smr_pkg;

  localparam int SMR_REG_AW = 8;
  localparam int SMR_TBL_AW = 8;
  localparam int SMR_IDX_W = 2;

  // Register offsets
  localparam logic [7:0] SMR_REG_CTRL = 8'h00;
  localparam logic [7:0] SMR_REG_STATUS = 8'h04;
  localparam logic [7:0] SMR_REG_RDCNT = 8'h08;
  localparam logic [7:0] SMR_REG_WIDX = 8'h0c;
  localparam logic [7:0] SMR_REG_WORD = 8'h10;

  localparam int SMR_CTRL_EN_BIT = 0;
  localparam int SMR_CTRL_ALT_BIT = 1;
  localparam logic [1:0] SMR_CTRL_RST = 2'h3;
  localparam int SMR_STAT_SIZE_BIT = 0;
  localparam int SMR_STAT_MISS_BIT = 1;
  localparam int SMR_STAT_LAST_LSB = 8;
  localparam logic [SMR_IDX_W-1:0] SMR_WIDX_RST = 2'h0;
  localparam logic [7:0] SMR_BYTE_RST = 8'h00;

  // Table window in the primary space, and the alternate space shift
  localparam logic [7:0] SMR_TBL_BASE = 8'h58;
  localparam logic [7:0] SMR_TBL_LAST = 8'h67;
  localparam logic [7:0] SMR_ALT_SHIFT = 8'h02;
  localparam logic [7:0] SMR_FILL = 8'hff;

  // Last detection descriptor
  localparam logic [7:0] SMR_DET_MASK = 8'h02;
  localparam logic [1:0] SMR_DET_ALEN = 2'h3;
  localparam logic [1:0] SMR_DET_RFU2 = 2'h3;
  localparam logic [3:0] SMR_DET_LAT = 4'hf;
  localparam logic [7:0] SMR_DET_INSTR = 8'h65;
  localparam logic [5:0] SMR_RFU6 = 6'h3f;
  localparam logic SMR_DET_CMD_DESC = 1'b0;
  localparam logic SMR_DET_LAST = 1'b1;
  localparam logic [31:0] SMR_DET_ADDR = 32'h0000_0004;

  // Configuration-0 header and its first region
  localparam logic [7:0] SMR_MAP_RFU = 8'hff;
  localparam logic [7:0] SMR_MAP_RCNT = 8'h02;
  localparam logic [7:0] SMR_MAP_CFGID = 8'h00;
  localparam logic SMR_MAP_DESC = 1'b1;
  localparam logic SMR_MAP_LAST = 1'b0;
  localparam logic [23:0] SMR_R0_SIZE = 24'h00007f;
  localparam logic [3:0] SMR_R0_RFU = 4'hf;
  localparam logic [3:0] SMR_R0_ERASE = 4'h1;

  typedef enum logic [1:0] {
    SMR_ST_IDLE = 2'b01,
    SMR_ST_RESP = 2'b10
  } smr_state_e;

endpackage

// ### design/smr_rom.sv
// Purpose: Constant store of four table dwords
// Assumes: Index 0 is the dword at the table base
// Notes: Bytes are picked least significant first by the reader
`timescale 1ns/1ns
`default_nettype none
module smr_rom (
  smr_rom_if.rom port
);
  import smr_pkg::*;

  always_comb begin
    case (port.idx)
      2'd0: port.dword = {SMR_DET_MASK, SMR_DET_ALEN, SMR_DET_RFU2, SMR_DET_LAT, SMR_DET_INSTR,
                          SMR_RFU6, SMR_DET_CMD_DESC, SMR_DET_LAST}; // see RULE_01 RULE_02 RULE_03 RULE_04 RULE_06
      2'd1: port.dword = SMR_DET_ADDR; // see RULE_05
      2'd2: port.dword = {SMR_MAP_RFU, SMR_MAP_RCNT, SMR_MAP_CFGID,
                          SMR_RFU6, SMR_MAP_DESC, SMR_MAP_LAST}; // see RULE_07 RULE_08 RULE_09
      2'd3: port.dword = {SMR_R0_SIZE, SMR_R0_RFU, SMR_R0_ERASE}; // see RULE_10 RULE_11
      default: port.dword = {4{SMR_FILL}};
    endcase
  end

endmodule
`default_nettype wire

// ### design/smr_rom_if.sv
// Purpose: Dword lookup channel between the server and the table store
// Assumes: Purely combinational lookup
// Notes: One instance per reader
`timescale 1ns/1ns
`default_nettype none
interface smr_rom_if;
  logic [smr_pkg::SMR_IDX_W-1:0] idx;
  logic [31:0] dword;
  modport client(output idx, input dword);
  modport rom(input idx, output dword);
endinterface
`default_nettype wire

// ### design/smr_sync2.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Pin is asynchronous to sys_clk
// Notes: First stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module smr_sync2 #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '0;
      q <= '0;
    end else if (clk_en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ### design/smr_top.sv
// Purpose: Serves a slice of the sector map parameter table byte by byte
// Assumes: Command decoding happens upstream; requests arrive on sys_clk
// Notes: Read data is registered and valid one cycle after the request
//
// Notes on behaviour
// RULE_01: Detect mask byte selects bit one
// RULE_02: Detect instruction is read-any-register 65h
// RULE_03: Address length and latency both variable
// RULE_04: Detect descriptor bit zero marks last
// RULE_05: Detect address is the config register four
// RULE_06: Command descriptor bit clear, upper bits ones
// RULE_07: Three regions, configuration id zero
// RULE_08: Header top byte reads all ones
// RULE_09: Header is map descriptor, more follow
// RULE_10: First region size code is 7Fh
// RULE_11: Only erase type one supported, top ones
// RULE_12: Little-endian bytes, alternate space two higher
`timescale 1ns/1ns
`default_nettype none
module smr_top #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [smr_pkg::SMR_REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic tbl_rd,
  input wire logic tbl_space,
  input wire logic [smr_pkg::SMR_TBL_AW-1:0] tbl_addr,
  output logic [7:0] tbl_rdata,
  output logic tbl_valid,
  output logic tbl_hit,
  input wire logic sector_size_pin,
  output logic uniform_sector_size_select
);
  import smr_pkg::*;

  logic [1:0] ctrl_r;
  logic miss_r;
  logic [CNT_W-1:0] rdcnt_r;
  logic [SMR_IDX_W-1:0] widx_r;
  logic [7:0] last_byte_r;
  logic [7:0] tbl_rdata_r;
  logic tbl_hit_r;
  logic [31:0] reg_rdata_r;
  smr_state_e state_r;
  smr_state_e state_nxt;

  logic size_sync;
  logic [7:0] prim_ofs;
  logic [7:0] rel_ofs;
  logic in_window;
  logic alt_ok;
  logic hit_now;
  logic [1:0] lane;
  logic [7:0] lane_byte;
  logic miss_evt;
  logic miss_clr;
  logic step;

  smr_rom_if tbl_if ();
  smr_rom_if word_if ();

  smr_rom u_rom_tbl (
    .port(tbl_if.rom)
  );

  smr_rom u_rom_word (
    .port(word_if.rom)
  );

  smr_sync2 #(
    .W(1)
  ) u_size_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .d(sector_size_pin),
    .q(size_sync)
  );

  // Alternate space sits two above the primary one
  always_comb begin
    prim_ofs = tbl_space ? 8'(tbl_addr - SMR_ALT_SHIFT) : tbl_addr; // see RULE_12
    in_window = (prim_ofs >= SMR_TBL_BASE) && (prim_ofs <= SMR_TBL_LAST);
    rel_ofs = 8'(prim_ofs - SMR_TBL_BASE);
    // Low alternate addresses wrap to FEh and FFh, which lie outside the window
    alt_ok = !tbl_space || (ctrl_r[SMR_CTRL_ALT_BIT] && (tbl_addr >= SMR_ALT_SHIFT));
    hit_now = ctrl_r[SMR_CTRL_EN_BIT] && in_window && alt_ok;
    lane = rel_ofs[1:0];
  end

  assign tbl_if.idx = rel_ofs[3:2];
  assign word_if.idx = widx_r;
  assign lane_byte = tbl_if.dword[8*lane +: 8]; // see RULE_12

  assign step = clk_en && tbl_rd;
  assign miss_evt = step && !hit_now;
  assign miss_clr = clk_en && reg_wr && (reg_addr == SMR_REG_STATUS) && reg_wdata[SMR_STAT_MISS_BIT];

  // Response sequencer; back-to-back requests keep it in RESP
  always_comb begin
    case (state_r)
      SMR_ST_IDLE: state_nxt = tbl_rd ? SMR_ST_RESP : SMR_ST_IDLE;
      SMR_ST_RESP: state_nxt = tbl_rd ? SMR_ST_RESP : SMR_ST_IDLE;
      default: state_nxt = SMR_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SMR_ST_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  assign tbl_valid = (state_r == SMR_ST_RESP);

  // Table byte out; misses read as erased fill
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tbl_rdata_r <= SMR_BYTE_RST;
      tbl_hit_r <= 1'b0;
    end else if (step) begin
      tbl_rdata_r <= hit_now ? lane_byte : SMR_FILL;
      tbl_hit_r <= hit_now;
    end
  end

  assign tbl_rdata = tbl_rdata_r;
  assign tbl_hit = tbl_hit_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      last_byte_r <= SMR_BYTE_RST;
    end else if (step && hit_now) begin
      last_byte_r <= lane_byte;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= SMR_CTRL_RST;
    end else if (clk_en && reg_wr && (reg_addr == SMR_REG_CTRL)) begin
      ctrl_r <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      widx_r <= SMR_WIDX_RST;
    end else if (clk_en && reg_wr && (reg_addr == SMR_REG_WIDX)) begin
      widx_r <= reg_wdata[SMR_IDX_W-1:0];
    end
  end

  // Sticky miss flag: a new miss beats a clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      miss_r <= 1'b0;
    end else if (clk_en) begin
      miss_r <= (miss_r && !miss_clr) || miss_evt;
    end
  end

  // Hit counter saturates rather than wrapping so software never sees a false low
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdcnt_r <= '0;
    end else if (clk_en && reg_wr && (reg_addr == SMR_REG_RDCNT)) begin
      rdcnt_r <= '0;
    end else if (step && hit_now && (rdcnt_r != '1)) begin
      rdcnt_r <= rdcnt_r + 1'b1;
    end
  end

  assign uniform_sector_size_select = size_sync;

  // Register read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_r <= '0;
    end else if (clk_en) begin
      reg_rdata_r <= '0;
      if (reg_rd) begin
        case (reg_addr)
          SMR_REG_CTRL: reg_rdata_r <= {30'h0, ctrl_r};
          SMR_REG_STATUS: reg_rdata_r <= {16'h0, last_byte_r, 6'h0, miss_r, size_sync};
          SMR_REG_RDCNT: reg_rdata_r <= 32'(rdcnt_r);
          SMR_REG_WIDX: reg_rdata_r <= {30'h0, widx_r};
          SMR_REG_WORD: reg_rdata_r <= word_if.dword;
          default: reg_rdata_r <= '0;
        endcase
      end
    end
  end

  assign reg_rdata = reg_rdata_r;

  // Checks on the served bytes
  logic prim_req;
  logic alt_req;
  assign prim_req = step && hit_now && !tbl_space;
  assign alt_req = step && hit_now && tbl_space;

  property p_r01_mask;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && (tbl_addr == 8'h5b) |=> (tbl_rdata == 8'h02) && tbl_hit;
  endproperty
  a_r01_mask: assert property (p_r01_mask) else $error("detect mask byte wrong"); // see RULE_01

  property p_r02_instr;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && (tbl_addr == 8'h59) |=> tbl_rdata == 8'h65;
  endproperty
  a_r02_instr: assert property (p_r02_instr) else $error("detect instruction byte wrong"); // see RULE_02

  property p_r03_alen_lat;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && (tbl_addr == 8'h5a) |=> (tbl_rdata[7:6] == 2'b11) && (tbl_rdata[3:0] == 4'b1111);
  endproperty
  a_r03_alen_lat: assert property (p_r03_alen_lat) else $error("variable length or latency code wrong"); // see RULE_03

  property p_r04_last;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && (tbl_addr == 8'h58) |=> tbl_valid && tbl_rdata[0];
  endproperty
  a_r04_last: assert property (p_r04_last) else $error("end descriptor bit not set"); // see RULE_04

  property p_r05_addr;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && (tbl_addr == 8'h5c) |=> tbl_rdata == 8'h04;
  endproperty
  a_r05_addr: assert property (p_r05_addr) else $error("detect address low byte wrong"); // see RULE_05

  property p_r05_hi;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && (tbl_addr >= 8'h5d) && (tbl_addr <= 8'h5f) |=> tbl_rdata == 8'h00;
  endproperty
  a_r05_hi: assert property (p_r05_hi) else $error("detect address upper bytes not zero"); // see RULE_05

  property p_r06_desc;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && (tbl_addr == 8'h58) |=> (tbl_rdata[7:1] == 7'b1111110);
  endproperty
  a_r06_desc: assert property (p_r06_desc) else $error("command descriptor bits wrong"); // see RULE_06

  property p_r07_count_id;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && ((tbl_addr == 8'h61) || (tbl_addr == 8'h62))
      |=> tbl_rdata == (($past(tbl_addr) == 8'h62) ? 8'h02 : 8'h00);
  endproperty
  a_r07_count_id: assert property (p_r07_count_id) else $error("region count or configuration id wrong"); // see RULE_07

  property p_r08_rfu;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && (tbl_addr == 8'h63) |=> tbl_rdata == 8'hff;
  endproperty
  a_r08_rfu: assert property (p_r08_rfu) else $error("header reserved byte not ones"); // see RULE_08

  property p_r09_map;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && (tbl_addr == 8'h60) |=> (tbl_rdata[1:0] == 2'b10) && (tbl_rdata[7:2] == 6'h3f);
  endproperty
  a_r09_map: assert property (p_r09_map) else $error("map descriptor bits wrong"); // see RULE_09

  property p_r10_size;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && (tbl_addr == 8'h65) |=> tbl_rdata == 8'h7f;
  endproperty
  a_r10_size: assert property (p_r10_size) else $error("region size byte wrong"); // see RULE_10

  property p_r11_erase;
    @(posedge sys_clk) disable iff (!reset_n)
      prim_req && (tbl_addr == 8'h64) |=> tbl_rdata == 8'hf1;
  endproperty
  a_r11_erase: assert property (p_r11_erase) else $error("erase support byte wrong"); // see RULE_11

  property p_r12_alt;
    @(posedge sys_clk) disable iff (!reset_n)
      alt_req && (tbl_addr == 8'h5a) |=> (tbl_rdata == 8'hfd) && tbl_hit;
  endproperty
  a_r12_alt: assert property (p_r12_alt) else $error("alternate space byte misplaced"); // see RULE_12

  property p_r12_miss;
    @(posedge sys_clk) disable iff (!reset_n)
      step && !hit_now |=> (tbl_rdata == 8'hff) && !tbl_hit && miss_r;
  endproperty
  a_r12_miss: assert property (p_r12_miss) else $error("out-of-window read not filled"); // see RULE_12

  // Handshake, freeze, alternate-disable, miss-clear and word-view checks
  property p_r12_valid;
    @(posedge sys_clk) disable iff (!reset_n)
      step |=> tbl_valid;
  endproperty
  a_r12_valid: assert property (p_r12_valid) else $error("accepted request got no valid"); // see RULE_12

  property p_r12_quiet;
    @(posedge sys_clk) disable iff (!reset_n)
      clk_en && !tbl_rd |=> !tbl_valid;
  endproperty
  a_r12_quiet: assert property (p_r12_quiet) else $error("valid without a request"); // see RULE_12

  property p_r12_freeze;
    @(posedge sys_clk) disable iff (!reset_n)
      !clk_en |=> $stable(tbl_rdata) && $stable(tbl_hit) && $stable(tbl_valid);
  endproperty
  a_r12_freeze: assert property (p_r12_freeze) else $error("table outputs moved while frozen"); // see RULE_12

  property p_r12_alt_off;
    @(posedge sys_clk) disable iff (!reset_n)
      step && tbl_space && !ctrl_r[SMR_CTRL_ALT_BIT] |=> !tbl_hit && (tbl_rdata == SMR_FILL);
  endproperty
  a_r12_alt_off: assert property (p_r12_alt_off) else $error("alternate read served while disabled"); // see RULE_12

  property p_r12_miss_clr;
    @(posedge sys_clk) disable iff (!reset_n)
      miss_clr && !miss_evt |=> !miss_r;
  endproperty
  a_r12_miss_clr: assert property (p_r12_miss_clr) else $error("miss flag not cleared"); // see RULE_12

  property p_r05_word;
    @(posedge sys_clk) disable iff (!reset_n)
      clk_en && reg_rd && (reg_addr == SMR_REG_WORD) && (widx_r == 2'h1) |=> reg_rdata == 32'h0000_0004;
  endproperty
  a_r05_word: assert property (p_r05_word) else $error("word view of detect address wrong"); // see RULE_05

  property p_r10_word;
    @(posedge sys_clk) disable iff (!reset_n)
      clk_en && reg_rd && (reg_addr == SMR_REG_WORD) && (widx_r == 2'h3) |=> reg_rdata == 32'h0000_7ff1;
  endproperty
  a_r10_word: assert property (p_r10_word) else $error("word view of first region wrong"); // see RULE_10 RULE_11

  c_prim_read: cover property (@(posedge sys_clk) disable iff (!reset_n) prim_req ##1 tbl_valid);
  c_alt_read: cover property (@(posedge sys_clk) disable iff (!reset_n) alt_req ##1 tbl_hit);
  c_miss_race: cover property (@(posedge sys_clk) disable iff (!reset_n) miss_evt && miss_clr);
  c_burst: cover property (@(posedge sys_clk) disable iff (!reset_n) step [*4]);
  c_frozen_req: cover property (@(posedge sys_clk) disable iff (!reset_n) !clk_en && tbl_rd);

endmodule
`default_nettype wire

// ### verification/smr_host_model.sv
// Purpose: Host side that fetches table bytes from the block
// Assumes: Answer is registered on the taking edge and read 1 ns after it
// Notes: Address is scrambled once a request ends, so stale values never match
`timescale 1ns/1ns
`default_nettype none
module smr_host_model (
  input wire logic sys_clk,
  input wire logic tbl_valid,
  input wire logic [7:0] tbl_rdata,
  input wire logic tbl_hit,
  output logic tbl_rd,
  output logic tbl_space,
  output logic [7:0] tbl_addr
);
  initial begin
    tbl_rd = 1'h0;
    tbl_space = 1'h0;
    tbl_addr = 8'h00;
  end

  // Missing valid hands back unknown data so the caller's compare fails
  task automatic fetch(input logic space, input logic [7:0] addr, output logic [7:0] data, output logic hit);
    @(posedge sys_clk);
    tbl_rd <= 1'h1;
    tbl_space <= space;
    tbl_addr <= addr;
    @(posedge sys_clk);
    tbl_rd <= 1'h0;
    tbl_addr <= ~addr;
    #1;
    data = tbl_valid ? tbl_rdata : 8'hxx;
    hit = tbl_hit;
  endtask
endmodule
`default_nettype wire

// ### verification/smr_top_tb.sv
// Purpose: Self-checking bench for the sector map table slice
// Assumes: Register reads answer one cycle after the strobe
// Notes: Expected dwords are rebuilt here from their fields
`timescale 1ns/1ns
`default_nettype none
module smr_top_tb;
  import smr_pkg::*;
  logic sys_clk, reset_n, clk_en, reg_wr, reg_rd, tbl_rd, tbl_space, sector_size_pin;
  logic [7:0] reg_addr, tbl_addr, tbl_rdata, d, h8;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic tbl_valid, tbl_hit, uniform_sector_size_select, h;
  logic [31:0] exp_dw [4];
  logic [8:0] miss_tab [5];
  int miscompares, check_count, cyc;

  smr_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tbl_rd(tbl_rd),
    .tbl_space(tbl_space), .tbl_addr(tbl_addr), .tbl_rdata(tbl_rdata), .tbl_valid(tbl_valid),
    .tbl_hit(tbl_hit), .sector_size_pin(sector_size_pin),
    .uniform_sector_size_select(uniform_sector_size_select));

  smr_host_model host (.sys_clk(sys_clk), .tbl_valid(tbl_valid), .tbl_rdata(tbl_rdata),
    .tbl_hit(tbl_hit), .tbl_rd(tbl_rd), .tbl_space(tbl_space), .tbl_addr(tbl_addr));

  always #20 sys_clk = ~sys_clk;

  // Tests need about 140 cycles; generous ceiling
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_word({24'h0, got}, {24'h0, exp});
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1;
    v = reg_rdata;
  endtask

  initial begin
    sys_clk = 1'h0;
    reset_n = 1'h0;
    clk_en = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    sector_size_pin = 1'h0;
    cyc = 0;
    exp_dw[0] = {8'h02, 2'h3, 2'h3, 4'hf, 8'h65, 6'h3f, 1'h0, 1'h1};
    exp_dw[1] = 32'h0000_0004;
    exp_dw[2] = {8'hff, 8'h02, 8'h00, 6'h3f, 1'h1, 1'h0};
    exp_dw[3] = {24'h00007f, 4'hf, 4'h1};
    miss_tab = '{9'h057, 9'h068, 9'h159, 9'h16a, 9'h100};
    repeat (4) @(posedge sys_clk);
    #1;
    chk_bit(tbl_valid, 1'h0);
    chk_byte(tbl_rdata, 8'h00);
    @(posedge sys_clk);
    reset_n <= 1'h1;
    reg_read(SMR_REG_CTRL, rd);
    chk_word(rd, 32'h3);
    // Read data must drop back the cycle after
    @(posedge sys_clk);
    #1;
    chk_word(reg_rdata, 32'h0);
    reg_write(SMR_REG_RDCNT, 32'h0);
    host.fetch(1'h0, 8'h58, d, h);
    host.fetch(1'h0, 8'h59, d, h);
    reg_read(SMR_REG_RDCNT, rd);
    chk_word(rd, 32'h2);
    reg_read(8'h20, rd);
    chk_word(rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      host.fetch(1'h0, 8'h58 + 8'(i), d, h);
      chk_byte(d, exp_dw[i / 4][8 * (i % 4) +: 8]);
      chk_bit(h, 1'h1);
      host.fetch(1'h1, 8'h5a + 8'(i), d, h);
      chk_byte(d, exp_dw[i / 4][8 * (i % 4) +: 8]);
    end
    @(posedge sys_clk);
    #1;
    chk_bit(tbl_valid, 1'h0);
    for (int i = 0; i < 4; i++) begin
      reg_write(SMR_REG_WIDX, 32'(i));
      reg_read(SMR_REG_WORD, rd);
      case (i)
        0: chk_word(rd, exp_dw[0]);
        1: chk_word(rd, exp_dw[1]);
        2: chk_word(rd, exp_dw[2]);
        default: chk_word(rd, exp_dw[3]);
      endcase
    end
    for (int i = 0; i < 5; i++) begin
      host.fetch(miss_tab[i][8], miss_tab[i][7:0], d, h);
      chk_byte(d, SMR_FILL);
      chk_bit(h, 1'h0);
    end
    reg_write(SMR_REG_CTRL, 32'h1);
    host.fetch(1'h1, 8'h5a, d, h);
    chk_bit(h, 1'h0);
    reg_write(SMR_REG_CTRL, 32'h0);
    host.fetch(1'h0, 8'h58, d, h);
    chk_byte(d, SMR_FILL);
    reg_write(SMR_REG_CTRL, 32'h3);
    host.fetch(1'h0, 8'h58, d, h);
    reg_read(SMR_REG_STATUS, rd);
    chk_word(rd, 32'h0000_fd02);
    reg_write(SMR_REG_STATUS, 32'h2);
    reg_read(SMR_REG_STATUS, rd);
    chk_word(rd, 32'h0000_fd00);
    // Frozen clock enable: request must not be taken
    @(posedge sys_clk);
    clk_en <= 1'h0;
    host.fetch(1'h0, 8'h59, h8, h);
    chk_bit(tbl_valid, 1'h0);
    chk_byte(tbl_rdata, 8'hfd);
    chk_bit(h, 1'h1);
    @(posedge sys_clk);
    clk_en <= 1'h1;
    sector_size_pin <= 1'h1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk_bit(uniform_sector_size_select, 1'h1);
    reg_read(SMR_REG_STATUS, rd);
    chk_bit(rd[SMR_STAT_SIZE_BIT], 1'h1);
    end_sim();
  end
endmodule
`default_nettype wire
